// [design/dlc_pkg.sv]
// Purpose: Constants and types for the deserializer lock and output state control block.
// Assumes: 10 MHz CLK; plain register port with 8-bit data and 8-bit byte address.
// Notes: All offsets, field positions, reset values and cycle counts live here.
package dlc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;

	// Control register fields
	localparam int CTRL_OSC_EN_BIT = 0;
	localparam int CTRL_FREQ_LSB = 1;
	localparam int CTRL_IDLE_SEL_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Status register fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_SLEEP_BIT = 1;
	localparam int STAT_SRC_OSC_BIT = 2;
	localparam int STAT_HOLD_BIT = 3;
	localparam int STAT_STATE_LSB = 4;

	// Link timing, in CLK cycles of consecutive embedded-clock presence or absence
	localparam logic [7:0] LOCK_CYCLES = 8'h10;
	localparam logic [7:0] LOSS_CYCLES = 8'h04;
	localparam logic [7:0] STOP_CYCLES = 8'h40;

	// Oscillator half periods in CLK cycles, one per frequency select code
	localparam logic [7:0] OSC_HALF_0 = 8'h02;
	localparam logic [7:0] OSC_HALF_1 = 8'h04;
	localparam logic [7:0] OSC_HALF_2 = 8'h08;
	localparam logic [7:0] OSC_HALF_3 = 8'h10;

	typedef enum logic [2:0] {
		ST_DOWN = 3'b000,
		ST_ACQ = 3'b001,
		ST_LOCK = 3'b010,
		ST_SLEEP = 3'b011,
		ST_AUTO_DOWN = 3'b100
	} dlc_state_e;

endpackage

// [design/dlc_top.sv]
// Purpose: Lock status and parallel output state control of the deserializer.
// Assumes: All inputs except the async reset RSTN synchronous to CLK; embedded clock presence given per cycle by the link.
// Notes: Every output comes from a flip-flop, so outputs trail their causes by one cycle.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
module dlc_top (
	input wire logic CLK, // 10 MHz clock
	input wire logic RSTN, // Async reset, active low
	input wire logic CE, // Clock enable, freezes state when low
	input wire logic POWER_DOWN_N_INPUT, // Low powers the block down
	input wire logic PARALLEL_OUTPUT_DRIVE_ENABLE, // High lets outputs drive
	input wire logic IDLE_OUTPUT_STATE_SELECT, // Pin default for idle state select
	input wire logic FALLBACK_OSCILLATOR_SELECT, // Pin default for oscillator enable
	input wire logic AUTO_DETECT_EN, // High: stream stop means power-down
	input wire logic EMBED_CLK_PRESENT, // Embedded clock bits seen this cycle
	input wire logic RECOV_CLK_LEVEL, // Level of recovered clock
	input wire logic [3:0] RECOV_DATA, // Recovered lane data
	input wire logic SELFTEST_RESULT_IN, // Self-test result from checker
	input wire logic [7:0] ADDR, // Register byte address
	input wire logic [7:0] WDATA, // Register write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [7:0] RDATA, // Read data, cycle after RD
	output logic LOCK_FLAG, // High when locked
	output logic SLEEP_STATE, // High in stop-stream sleep
	output logic PARALLEL_CLOCK_OUT, // Parallel clock level
	output logic PARALLEL_CLOCK_OE, // Parallel clock drive enable
	output logic [3:0] PARALLEL_DATA_LANES, // Parallel data lanes
	output logic PARALLEL_DATA_OE, // Data lanes drive enable
	output logic SELFTEST_PASS_OUT, // Self-test result pin
	output logic SELFTEST_PASS_OE // Self-test pin drive enable
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Saturating increment keeps the run counters from wrapping
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == 8'hff) ? v : v + 8'h01;
	endfunction

	// Oscillator half period for a frequency select code
	function automatic logic [7:0] osc_half(input logic [1:0] sel);
		case (sel)
			2'h0: osc_half = dlc_pkg::OSC_HALF_0;
			2'h1: osc_half = dlc_pkg::OSC_HALF_1;
			2'h2: osc_half = dlc_pkg::OSC_HALF_2;
			default: osc_half = dlc_pkg::OSC_HALF_3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	dlc_pkg::dlc_state_e state_reg, state_next;
	logic [7:0] run_reg, run_next;
	logic [7:0] gap_reg, gap_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] osc_cnt_reg, osc_cnt_next;
	logic osc_lvl_reg, osc_lvl_next;
	logic src_osc_reg;
	logic hold_reg, hold_next;
	logic [7:0] rdata_next;
	logic [7:0] status_word;
	logic pd_active, powered, is_lock, osc_en, idle_sel, parallel_output_drive_enable;
	logic src_osc, src_chg, new_lvl, clk_next, clk_oe_next;
	logic [3:0] data_next;
	logic data_oe_next, pass_next, pass_oe_next;
	logic osc_wrap;

	////////////////////////////////////////////////////////////////////////////
	// Lock state machine

	// Power-down pin or auto-detect stop both count as power-down
	assign pd_active = !POWER_DOWN_N_INPUT || (state_reg == dlc_pkg::ST_AUTO_DOWN);
	assign powered = POWER_DOWN_N_INPUT && (state_reg != dlc_pkg::ST_DOWN)
		&& (state_reg != dlc_pkg::ST_AUTO_DOWN);
	assign is_lock = (state_reg == dlc_pkg::ST_LOCK);

	// Consecutive presence and absence of embedded clock bits
	assign run_next = EMBED_CLK_PRESENT ? sat_inc(run_reg) : 8'h00;
	assign gap_next = EMBED_CLK_PRESENT ? 8'h00 : sat_inc(gap_reg);

	// Power-down wins over every link event
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dlc_pkg::ST_DOWN: begin
				state_next = dlc_pkg::ST_ACQ;
			end
			dlc_pkg::ST_ACQ: begin
				if (run_next >= dlc_pkg::LOCK_CYCLES) begin
					state_next = dlc_pkg::ST_LOCK;
				end else if (gap_next >= dlc_pkg::STOP_CYCLES) begin
					state_next = AUTO_DETECT_EN ? dlc_pkg::ST_AUTO_DOWN : dlc_pkg::ST_SLEEP;
				end
			end
			dlc_pkg::ST_LOCK: begin
				if (gap_next >= dlc_pkg::LOSS_CYCLES) begin
					state_next = dlc_pkg::ST_ACQ;
				end
			end
			dlc_pkg::ST_SLEEP: begin
				if (EMBED_CLK_PRESENT) begin
					state_next = dlc_pkg::ST_ACQ;
				end
			end
			dlc_pkg::ST_AUTO_DOWN: begin
				if (EMBED_CLK_PRESENT) begin
					state_next = dlc_pkg::ST_ACQ;
				end
			end
			default: begin
				state_next = dlc_pkg::ST_DOWN;
			end
		endcase
		if (!POWER_DOWN_N_INPUT) begin
			state_next = dlc_pkg::ST_DOWN;
		end
	end

	// State and run counters
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= dlc_pkg::ST_DOWN;
			run_reg <= 8'h00;
			gap_reg <= 8'h00;
		end else if (CE) begin
			state_reg <= state_next;
			run_reg <= run_next;
			gap_reg <= gap_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register

	assign osc_en = ctrl_reg[dlc_pkg::CTRL_OSC_EN_BIT];
	assign idle_sel = ctrl_reg[dlc_pkg::CTRL_IDLE_SEL_BIT];
	assign parallel_output_drive_enable = PARALLEL_OUTPUT_DRIVE_ENABLE;

	// Pins load the defaults while powered down; software overrides afterwards.
	// Sleep keeps the register, since only power-down reloads it.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (pd_active) begin
			ctrl_next = dlc_pkg::CTRL_RESET;
			ctrl_next[dlc_pkg::CTRL_OSC_EN_BIT] = FALLBACK_OSCILLATOR_SELECT;
			ctrl_next[dlc_pkg::CTRL_IDLE_SEL_BIT] = IDLE_OUTPUT_STATE_SELECT;
		end else if (WR && (ADDR == dlc_pkg::ADDR_CTRL)) begin
			ctrl_next = {4'h0, WDATA[3:0]};
		end
	end

	// Status word seen by software
	assign status_word = {1'b0, state_reg, hold_reg, src_osc_reg,
		(state_reg == dlc_pkg::ST_SLEEP), is_lock};

	// Read decode; unmapped addresses read zero
	assign rdata_next = !RD ? 8'h00 :
		(ADDR == dlc_pkg::ADDR_CTRL) ? ctrl_reg :
		(ADDR == dlc_pkg::ADDR_STATUS) ? status_word : 8'h00;

	// Register file and read port
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_reg <= dlc_pkg::CTRL_RESET;
			RDATA <= 8'h00;
		end else if (CE) begin
			ctrl_reg <= ctrl_next;
			RDATA <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fallback oscillator

	// Free-running divider; it runs whenever powered so the switch-over finds it going
	assign osc_wrap = (osc_cnt_reg >= osc_half(ctrl_reg[dlc_pkg::CTRL_FREQ_LSB +: 2]) - 8'h01);
	assign osc_cnt_next = (!powered || osc_wrap) ? 8'h00 : osc_cnt_reg + 8'h01;
	assign osc_lvl_next = !powered ? 1'b0 : (osc_wrap ? !osc_lvl_reg : osc_lvl_reg);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			osc_cnt_reg <= 8'h00;
			osc_lvl_reg <= 1'b0;
		end else if (CE) begin
			osc_cnt_reg <= osc_cnt_next;
			osc_lvl_reg <= osc_lvl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parallel clock source and glitch-free switch-over

	// Oscillator serves only while unlocked and enabled
	assign src_osc = !is_lock && osc_en;
	assign src_chg = (src_osc != src_osc_reg);
	assign new_lvl = src_osc ? osc_lvl_reg : (is_lock ? RECOV_CLK_LEVEL : 1'b0);
	// Hold the present level until the new source comes round to it, so no runt pulse
	assign hold_next = (src_chg || hold_reg) && (new_lvl != PARALLEL_CLOCK_OUT);
	assign clk_next = hold_next ? PARALLEL_CLOCK_OUT : new_lvl;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			src_osc_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else if (CE) begin
			src_osc_reg <= src_osc;
			hold_reg <= hold_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output state table

	// Clock drives when locked, or unlocked with oscillator bit or idle select low
	assign clk_oe_next = powered && parallel_output_drive_enable && (is_lock || osc_en || !idle_sel);
	// Lanes drive recovered data when locked, or low when idle select is low
	assign data_oe_next = powered && parallel_output_drive_enable && (is_lock || !idle_sel);
	assign data_next = is_lock ? RECOV_DATA : 4'h0;
	// Self-test pin drives only when locked; forced high while outputs are disabled
	assign pass_oe_next = powered && is_lock;
	assign pass_next = parallel_output_drive_enable ? SELFTEST_RESULT_IN : 1'b1;

	// Output flip-flops
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			LOCK_FLAG <= 1'b0;
			SLEEP_STATE <= 1'b0;
			PARALLEL_CLOCK_OUT <= 1'b0;
			PARALLEL_CLOCK_OE <= 1'b0;
			PARALLEL_DATA_LANES <= 4'h0;
			PARALLEL_DATA_OE <= 1'b0;
			SELFTEST_PASS_OUT <= 1'b0;
			SELFTEST_PASS_OE <= 1'b0;
		end else if (CE) begin
			LOCK_FLAG <= is_lock;
			SLEEP_STATE <= (state_reg == dlc_pkg::ST_SLEEP);
			PARALLEL_CLOCK_OUT <= clk_next;
			PARALLEL_CLOCK_OE <= clk_oe_next;
			PARALLEL_DATA_LANES <= data_next;
			PARALLEL_DATA_OE <= data_oe_next;
			SELFTEST_PASS_OUT <= pass_next;
			SELFTEST_PASS_OE <= pass_oe_next;
		end
	end

endmodule

// [sim/dlc_top_assertions.sv]
// Purpose: Port checks of the lock and output state block.
// Assumes: one clock; CE may drop for a few cycles, as the bench does.
// Notes: Bound to dlc_top below.
`timescale 1ns/1ns
module dlc_top_chk (
	input wire logic CLK, // Clock
	input wire logic RSTN, // Reset, low
	input wire logic CE, // Clock enable
	input wire logic [3:0] RECOV_DATA, // Recovered lanes in
	input wire logic POWER_DOWN_N_INPUT, // Power pin
	input wire logic PARALLEL_OUTPUT_DRIVE_ENABLE, // Drive pin
	input wire logic EMBED_CLK_PRESENT, // Link seen
	input wire logic LOCK_FLAG, // Lock
	input wire logic PARALLEL_CLOCK_OE, // Clock drive
	input wire logic [3:0] PARALLEL_DATA_LANES, // Lanes
	input wire logic PARALLEL_DATA_OE, // Lane drive
	input wire logic SELFTEST_PASS_OUT, // Pass pin
	input wire logic SELFTEST_PASS_OE // Pass drive
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	logic [7:0] run_cnt;
	////////////////////////////////////////////////////////////
	// Present run length, saturating so long runs never wrap
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) run_cnt <= 8'h00;
		else if (!EMBED_CLK_PRESENT) run_cnt <= 8'h00;
		else if (run_cnt != 8'hff) run_cnt <= run_cnt + 8'h01;
	end
	a_pd_all_tri: assert property (!POWER_DOWN_N_INPUT [*3] |-> !(PARALLEL_CLOCK_OE || PARALLEL_DATA_OE))
		else $error("pins driven in power-down");
	a_pd_pass_tri: assert property (!POWER_DOWN_N_INPUT [*3] |-> !SELFTEST_PASS_OE && !LOCK_FLAG)
		else $error("pass pin or lock in power-down");
	a_wake_no_lock: assert property ($rose(POWER_DOWN_N_INPUT) |-> !LOCK_FLAG [*8])
		else $error("lock too soon after wake");
	a_lanes_need_drive: assert property (PARALLEL_DATA_OE |-> $past(PARALLEL_OUTPUT_DRIVE_ENABLE))
		else $error("lanes driven while disabled");
	a_clock_need_drive: assert property (PARALLEL_CLOCK_OE |-> $past(PARALLEL_OUTPUT_DRIVE_ENABLE))
		else $error("clock driven while disabled");
	a_pass_high_off: assert property (SELFTEST_PASS_OE && !$past(PARALLEL_OUTPUT_DRIVE_ENABLE) |-> SELFTEST_PASS_OUT)
		else $error("pass pin not high");
	a_lock_after_run: assert property ($rose(LOCK_FLAG) |-> $past(run_cnt) >= 8'd15)
		else $error("lock without full run");
	a_loss_drops_lock: assert property (!EMBED_CLK_PRESENT [*7] |-> !LOCK_FLAG)
		else $error("lock kept on loss");
	a_unlock_lanes_zero: assert property (PARALLEL_DATA_OE && !LOCK_FLAG |-> PARALLEL_DATA_LANES == 4'h0)
		else $error("lanes not idle");
	// Frozen cycles are skipped, since lanes then keep an older word
	a_lock_lanes_pass: assert property (LOCK_FLAG && $past(CE) |-> PARALLEL_DATA_LANES == $past(RECOV_DATA))
		else $error("locked lanes not passing data");
endmodule
bind dlc_top dlc_top_chk u_chk (.*);

// [sim/dlc_serializer_model.sv]
// Purpose: Paired serializer seen through the recovery front end.
// Assumes: Stream runs while run is high.
// Notes: Stopped lanes flip each cycle so no stale value passes.
`timescale 1ns/1ns
module dlc_serializer_model (
	input wire logic clk, // Bench clock
	input wire logic run, // Stream on
	output logic present, // Embedded bits seen
	output logic clk_lvl, // Recovered clock
	output logic [3:0] data, // Recovered lanes
	output logic pass // Self-test result
);
	initial begin
		{present, clk_lvl, data, pass} = 7'h00;
	end
	////////////////////////////////////////////////////////////
	// Clock stands still between frames; lanes churn
	always @(posedge clk) begin
		present <= run;
		clk_lvl <= run ? ~clk_lvl : clk_lvl;
		data <= run ? data + 4'h3 : ~data;
		pass <= run ? data[0] : ~pass;
	end
endmodule

// [sim/tb_top.sv]
// Purpose: Self-checking bench of the lock and output block.
// Assumes: Pin defaults both high; CE high except during the frozen check.
// Notes: Expectations queue up and a monitor checks them.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((e) !== (a)) begin fails++; $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
	typedef struct {string n; logic [7:0] e; logic [7:0] m; bit o;} dlc_exp_s;
	logic CLK, RSTN, CE, POWER_DOWN_N_INPUT, PARALLEL_OUTPUT_DRIVE_ENABLE, IDLE_OUTPUT_STATE_SELECT, WR, RD;
	logic FALLBACK_OSCILLATOR_SELECT, AUTO_DETECT_EN, EMBED_CLK_PRESENT, RECOV_CLK_LEVEL, SELFTEST_RESULT_IN;
	logic LOCK_FLAG, SLEEP_STATE, PARALLEL_CLOCK_OUT, PARALLEL_CLOCK_OE, PARALLEL_DATA_OE;
	logic SELFTEST_PASS_OUT, SELFTEST_PASS_OE, run, rdq, smp, c;
	logic [3:0] RECOV_DATA, PARALLEL_DATA_LANES;
	logic [7:0] ADDR, WDATA, RDATA, r, n;
	logic [7:0] hp[4] = '{dlc_pkg::OSC_HALF_0, dlc_pkg::OSC_HALF_1, dlc_pkg::OSC_HALF_2, dlc_pkg::OSC_HALF_3};
	int fails, tests_run, k;
	integer seed;
	dlc_exp_s q[$];
	dlc_exp_s x;
	dlc_top dut (.*);
	dlc_serializer_model partner (.clk(CLK), .run(run), .present(EMBED_CLK_PRESENT), .clk_lvl(RECOV_CLK_LEVEL),
		.data(RECOV_DATA), .pass(SELFTEST_RESULT_IN));
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	////////////////////////////////////////////////////////////
	// Bits: pass out, lock, sleep, clock drive, lane drive, pass drive
	function automatic logic [7:0] obs();
		return {2'h0, SELFTEST_PASS_OUT, LOCK_FLAG, SLEEP_STATE, PARALLEL_CLOCK_OE, PARALLEL_DATA_OE, SELFTEST_PASS_OE};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(string s, logic [7:0] a, logic [7:0] e, logic [7:0] m);
		q.push_back('{s, e, m, 1'b0});
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
	endtask
	task automatic ex(string s, logic [7:0] e, logic [7:0] m);
		q.push_back('{s, e, m, 1'b1});
		@(posedge CLK);
		smp <= 1'b1;
		@(posedge CLK);
		smp <= 1'b0;
	endtask
	// Bounded wait; running out ends the run
	task automatic wt(logic [7:0] m, logic [7:0] v);
		for (int j = 0; j < 300; j++) begin
			@(negedge CLK);
			if ((obs() & m) === v) return;
		end
		fails++;
		$display("BAD wait %h exp %h got %h", m, v, obs());
		finish_test();
	endtask
	////////////////////////////////////////////////////////////
	// Oldest note is matched to the read data or output snapshot
	always @(posedge CLK) rdq <= RD;
	always @(negedge CLK) if (rdq || smp) begin
		x = q.pop_front();
		`CHK(x.n, x.e & x.m, (x.o ? obs() : RDATA) & x.m)
	end
	initial begin
		seed = 32'haa410839;
		{CE, IDLE_OUTPUT_STATE_SELECT, FALLBACK_OSCILLATOR_SELECT, PARALLEL_OUTPUT_DRIVE_ENABLE} = 4'hf;
		{RSTN, POWER_DOWN_N_INPUT, AUTO_DETECT_EN, WR, RD, run, rdq, smp} = 8'h00;
		{ADDR, WDATA} = 16'h0000;
		repeat (20) @(posedge CLK);
		RSTN <= 1'b1;
		wr(dlc_pkg::ADDR_CTRL, 8'h00);
		rd("ctrl pd", dlc_pkg::ADDR_CTRL, 8'h09, 8'h09);
		ex("pd pins", 8'h00, 8'h1f);
		rd("unmapped", 8'h08, 8'h00, 8'hff);
		$display("power-down test done");
		POWER_DOWN_N_INPUT <= 1'b1;
		run <= 1'b1;
		wt(8'h10, 8'h10);
		ex("locked", 8'h17, 8'h1f);
		rd("status", dlc_pkg::ADDR_STATUS, 8'h21, 8'h77);
		PARALLEL_OUTPUT_DRIVE_ENABLE <= 1'b0;
		wt(8'h04, 8'h00);
		ex("drive off", 8'h31, 8'h3f);
		// Enable low must freeze every output even though a pin changes
		CE <= 1'b0;
		PARALLEL_OUTPUT_DRIVE_ENABLE <= 1'b1;
		ex("frozen", 8'h31, 8'h3f);
		CE <= 1'b1;
		for (k = 0; k < 4; k++) begin
			r = 8'($random(seed));
			wr(dlc_pkg::ADDR_CTRL, r);
			rd("ctrl", dlc_pkg::ADDR_CTRL, r & 8'h0f, 8'hff);
		end
		$display("lock test done");
		wr(dlc_pkg::ADDR_CTRL, 8'h09);
		run <= 1'b0;
		wt(8'h10, 8'h00);
		ex("lost fallback", 8'h04, 8'h17);
		for (k = 0; k < 4; k++) begin
			wr(dlc_pkg::ADDR_CTRL, 8'h09 | 8'(k << 1));
			repeat (40) @(negedge CLK);
			c = PARALLEL_CLOCK_OUT;
			for (int j = 0; j < 40 && PARALLEL_CLOCK_OUT === c; j++) @(negedge CLK);
			c = PARALLEL_CLOCK_OUT;
			for (n = 8'h00; n < 8'h28 && PARALLEL_CLOCK_OUT === c; n++) @(negedge CLK);
			`CHK("half period", hp[k], n)
		end
		wr(dlc_pkg::ADDR_CTRL, 8'h08);
		wt(8'h04, 8'h00);
		ex("no fallback", 8'h00, 8'h17);
		wr(dlc_pkg::ADDR_CTRL, 8'h00);
		wt(8'h06, 8'h06);
		ex("idle low", 8'h06, 8'h17);
		wt(8'h08, 8'h08);
		rd("ctrl kept", dlc_pkg::ADDR_CTRL, 8'h00, 8'hff);
		rd("sleep", dlc_pkg::ADDR_STATUS, 8'h32, 8'h73);
		run <= 1'b1;
		wt(8'h10, 8'h10);
		$display("loss test done");
		@(posedge CLK);
		AUTO_DETECT_EN <= 1'b1;
		run <= 1'b0;
		wt(8'h17, 8'h00);
		rd("auto ctrl", dlc_pkg::ADDR_CTRL, 8'h09, 8'h09);
		rd("auto down", dlc_pkg::ADDR_STATUS, 8'h40, 8'h73);
		run <= 1'b1;
		wt(8'h10, 8'h10);
		ex("relock", 8'h17, 8'h1f);
		POWER_DOWN_N_INPUT <= 1'b0;
		wt(8'h17, 8'h00);
		ex("pd again", 8'h00, 8'h1f);
		$display("auto test done");
		finish_test();
	end
endmodule
